// file: core/csbc_top.sv
// clock source selection, oscillator enables and backup drive flag
// assumes oscillator clock inputs are synchronous to CLK and far slower
// Function
// - silver-oxide or lithium supply forces backup drive flag to one in reset
// - external-voltage supply clears backup drive flag to zero in reset
// - lithium bias: flag zero closes switch a, opens b; one reverses
// - lithium bias with flag one: logic on higher rail, stronger drive
// - clock routing follows build; dual fast mode moves only system clock
// - slow oscillator off in fast-only builds, else runs except in stop or reset
// - slow oscillator kind chosen at build: crystal or RC network
// - fast-only: fast feeds everything; dual: system clock generator only
// - dual: fast oscillator off until high-speed instruction, then system moves
// - halt, stop or low-speed instruction stop fast and return to slow
// - external-resistor fast RC only in fast-only builds, disables internal
// - internal fast RC offers 250KHz or 500KHz, fast-only or dual
// - flag one gives crystal higher drive and shorter start-up
// - supply is one of three kinds; display bias chosen separately
// - dual: wait twelve fast edges before system clock moves to fast
// - low-speed instruction: wait two slow edges before moving back
`timescale 1ns/10ps
`include "csbc_defines.svh"

module csbc_top #(
   parameter csbc_pkg::csbc_clk_src_t CLOCK_SOURCE = csbc_pkg::CSBC_SRC_DUAL,
   parameter csbc_pkg::csbc_supply_t SUPPLY = csbc_pkg::CSBC_SUP_AG,
   parameter csbc_pkg::csbc_bias_t BIAS = csbc_pkg::CSBC_BIAS_NONE,
   parameter csbc_pkg::csbc_slow_type_t SLOW_TYPE = csbc_pkg::CSBC_SLOW_XTAL,
   parameter csbc_pkg::csbc_fast_freq_t FAST_FREQ = csbc_pkg::CSBC_FREQ_250K,
   parameter int FAST_WAIT = `CSBC_FAST_WAIT,
   parameter int SLOW_WAIT = `CSBC_SLOW_WAIT
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // oscillator outputs, sampled as levels
   input wire logic SLOW_OSC_CLK,
   input wire logic HIGH_SPEED_OSC_CLK,
   // instruction strobes and sleep modes
   input wire logic FAST_INSN,
   input wire logic SLOW_INSN,
   input wire logic HALT_MODE,
   input wire logic STOP_MODE,
   // backup drive flag access
   input wire logic BACKUP_FLAG_WR,
   input wire logic BACKUP_FLAG_WDATA,
   output logic BACKUP_DRIVE_FLAG,
   // oscillator, routing and power controls
   output csbc_pkg::csbc_osc_ctl_t OSC_CTL,
   output csbc_pkg::csbc_clk_sel_t CLK_SEL,
   output csbc_pkg::csbc_power_t POWER_CTL,
   output logic FAST_MODE
);

   // build decode: all constants, folded away by synthesis
   // three supplies, bias separate
   localparam logic IS_DUAL = (CLOCK_SOURCE == csbc_pkg::CSBC_SRC_DUAL);
   localparam logic IS_FAST_INT = (CLOCK_SOURCE == csbc_pkg::CSBC_SRC_FAST_INT);
   localparam logic IS_FAST_EXT = (CLOCK_SOURCE == csbc_pkg::CSBC_SRC_FAST_EXT);
   localparam logic FAST_ONLY = IS_FAST_INT | IS_FAST_EXT;
   localparam logic LI_BIAS = (SUPPLY == csbc_pkg::CSBC_SUP_LI) &&
                              (BIAS != csbc_pkg::CSBC_BIAS_NONE);
   localparam logic BCF_RST = (SUPPLY == csbc_pkg::CSBC_SUP_EXTERNAL_VOLTAGE_SUPPLY_OPTION) ?
                              `CSBC_BCF_RST_EXTERNAL_VOLTAGE_SUPPLY_OPTION : `CSBC_BCF_RST_BATT;

   // edge detect state for the sampled oscillator clocks and stop mode, then flag and enable registers
   logic slow_prev_reg;
   logic fast_prev_reg;
   logic stop_prev_reg;
   logic bcf_reg, bcf_next;
   csbc_pkg::csbc_osc_ctl_t osc_reg, osc_next;

   // oscillator edges and stop entry as one-cycle pulses
   wire slow_edge = SLOW_OSC_CLK & ~slow_prev_reg;
   wire fast_edge = HIGH_SPEED_OSC_CLK & ~fast_prev_reg;
   wire stop_rise = STOP_MODE & ~stop_prev_reg;

   // switch outputs
   wire sw_fast_on;
   wire sw_sys_fast;

   // dual-build switch; instructions act as no-ops elsewhere
   csbc_switch #(
      .FAST_WAIT(FAST_WAIT),
      .SLOW_WAIT(SLOW_WAIT),
      .CNT_W(`CSBC_CNT_W)
   ) u_switch (
      .clk(CLK),
      .rst(RST),
      .enable(IS_DUAL),
      .fast_cmd(FAST_INSN),
      .slow_cmd(SLOW_INSN),
      .halt_mode(HALT_MODE),
      .stop_mode(STOP_MODE),
      .fast_edge(fast_edge),
      .slow_edge(slow_edge),
      .fast_osc_on(sw_fast_on),
      .sys_on_fast(sw_sys_fast)
   );

   // single clock builds raise the flag on the way into stop, so the
   // crystal restarts with strong drive; this set beats a software clear
   wire stop_set = ~IS_DUAL & stop_rise;

   assign bcf_next = stop_set ? `CSBC_BCF_STOP_SET :
                     BACKUP_FLAG_WR ? BACKUP_FLAG_WDATA : bcf_reg;

   // oscillator enables
   always_comb begin
      osc_next = '0;
      // slow off in fast-only, stop halts
      osc_next.slow_en = ~FAST_ONLY & ~STOP_MODE;
      osc_next.fast_int_en = IS_DUAL ? sw_fast_on : (IS_FAST_INT & ~STOP_MODE);
      osc_next.fast_ext_en = IS_FAST_EXT & ~STOP_MODE;
      osc_next.fast_freq_500 = ~IS_FAST_EXT & (FAST_FREQ == csbc_pkg::CSBC_FREQ_500K);
      osc_next.slow_xtal_sel = ~FAST_ONLY & (SLOW_TYPE == csbc_pkg::CSBC_SLOW_XTAL);
      osc_next.slow_rc_sel = ~FAST_ONLY & (SLOW_TYPE == csbc_pkg::CSBC_SLOW_RC);
   end

   // flags and edge history; oscillators all off during reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         bcf_reg <= BCF_RST;
         osc_reg <= '0;
         slow_prev_reg <= 1'h0;
         fast_prev_reg <= 1'h0;
         stop_prev_reg <= 1'h0;
      end else begin
         bcf_reg <= bcf_next;
         osc_reg <= osc_next;
         slow_prev_reg <= SLOW_OSC_CLK;
         fast_prev_reg <= HIGH_SPEED_OSC_CLK;
         stop_prev_reg <= STOP_MODE;
      end
   end

   // clock routing
   // build-dependent clock sources
   assign CLK_SEL.sys_fast = FAST_ONLY | (IS_DUAL & sw_sys_fast);
   assign CLK_SEL.prediv_fast = FAST_ONLY;
   assign CLK_SEL.periph_fast = FAST_ONLY;

   // power path: switches only matter with the lithium halver in use;
   // software must wait for the halver to settle before clearing the flag
   // switch a closed at zero
   assign POWER_CTL.halver_switch_a = LI_BIAS & ~bcf_reg;
   assign POWER_CTL.halver_switch_b = LI_BIAS & bcf_reg;
   assign POWER_CTL.high_rail = LI_BIAS & bcf_reg;
   assign POWER_CTL.high_drive = bcf_reg;

   // outputs
   assign OSC_CTL = osc_reg;
   assign BACKUP_DRIVE_FLAG = bcf_reg;
   assign FAST_MODE = CLK_SEL.sys_fast;

   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // reset value seen at the release edge; a plain RST antecedent would sit under the disable
   a_flag_reset: assert property (@(posedge CLK) $fell(RST) |-> BACKUP_DRIVE_FLAG == BCF_RST)
      else $error("backup drive flag wrong after reset");
   a_flag_external_voltage_supply_option: assert property (@(posedge CLK) $fell(RST) && SUPPLY == csbc_pkg::CSBC_SUP_EXTERNAL_VOLTAGE_SUPPLY_OPTION |-> !BACKUP_DRIVE_FLAG)
      else $error("external supply flag not cleared in reset");
   a_flag_write: assert property (BACKUP_FLAG_WR && !stop_set |=> BACKUP_DRIVE_FLAG == $past(BACKUP_FLAG_WDATA))
      else $error("backup drive flag write not taken");
   a_flag_hold: assert property (!BACKUP_FLAG_WR && !stop_set |=> $stable(BACKUP_DRIVE_FLAG))
      else $error("backup drive flag changed without cause");
   a_halver_pair: assert property (LI_BIAS |-> POWER_CTL.halver_switch_a != POWER_CTL.halver_switch_b)
      else $error("halver switches not complementary");
   a_rail_drive: assert property (POWER_CTL.high_rail |-> BACKUP_DRIVE_FLAG && POWER_CTL.high_drive)
      else $error("higher rail without flag set");
   a_slow_stop: assert property (STOP_MODE |=> !OSC_CTL.slow_en)
      else $error("slow oscillator running in stop");
   a_slow_run: assert property (!STOP_MODE && !FAST_ONLY |=> OSC_CTL.slow_en)
      else $error("slow oscillator not running");
   a_prediv_dual: assert property (IS_DUAL |-> !CLK_SEL.prediv_fast && !CLK_SEL.periph_fast)
      else $error("dual build moved a peripheral clock to fast");
   a_fast_excl: assert property (!(OSC_CTL.fast_int_en && OSC_CTL.fast_ext_en))
      else $error("both fast oscillator types enabled");
   a_sys_sleep: assert property (IS_DUAL && (HALT_MODE || STOP_MODE) |=> !CLK_SEL.sys_fast ##1 !OSC_CTL.fast_int_en)
      else $error("sleep did not return system clock to slow");

endmodule // csbc_top

// file: core/csbc_defines.svh
// clock source and backup control: counts, widths and reset values
// assumes inclusion by bare name from the core files
`ifndef CSBC_DEFINES_SVH
`define CSBC_DEFINES_SVH

// fast oscillator edges to wait before the system clock moves to it
`define CSBC_FAST_WAIT 12
// slow oscillator edges to wait before the system clock moves back
`define CSBC_SLOW_WAIT 2
// width of the switch wait counter
`define CSBC_CNT_W 4
// backup drive flag value in the initial reset cycle, battery supplies
`define CSBC_BCF_RST_BATT 1'h1
// backup drive flag value in the initial reset cycle, external supply
`define CSBC_BCF_RST_EXTERNAL_VOLTAGE_SUPPLY_OPTION 1'h0
// value forced into the flag on stop entry in single clock builds
`define CSBC_BCF_STOP_SET 1'h1

`endif

// file: core/csbc_pkg.sv
// clock source and backup control: shared types
// assumes csbc_defines.svh for all numeric constants
package csbc_pkg;

   // clock source build option
   typedef enum logic [1:0] {
      CSBC_SRC_FAST_INT = 2'b00,
      CSBC_SRC_FAST_EXT = 2'b01,
      CSBC_SRC_SLOW_ONLY = 2'b10,
      CSBC_SRC_DUAL = 2'b11
   } csbc_clk_src_t;

   // supply build option
   typedef enum logic [1:0] {
      CSBC_SUP_AG = 2'b00,
      CSBC_SUP_LI = 2'b01,
      CSBC_SUP_EXTERNAL_VOLTAGE_SUPPLY_OPTION = 2'b10
   } csbc_supply_t;

   // display bias build option
   typedef enum logic [1:0] {
      CSBC_BIAS_THIRD = 2'b00,
      CSBC_BIAS_HALF = 2'b01,
      CSBC_BIAS_NONE = 2'b10
   } csbc_bias_t;

   // slow oscillator kind: 32.768KHz crystal or RC network
   typedef enum logic {
      CSBC_SLOW_XTAL = 1'b0,
      CSBC_SLOW_RC = 1'b1
   } csbc_slow_type_t;

   // internal-resistor fast RC nominal: 250KHz or 500KHz
   typedef enum logic {
      CSBC_FREQ_250K = 1'b0,
      CSBC_FREQ_500K = 1'b1
   } csbc_fast_freq_t;

   // system clock switch states
   typedef enum logic [1:0] {
      CSBC_ST_SLOW = 2'b00,
      CSBC_ST_WAIT_FAST = 2'b01,
      CSBC_ST_FAST = 2'b10,
      CSBC_ST_WAIT_SLOW = 2'b11
   } csbc_state_t;

   // oscillator enables and selects
   typedef struct packed {
      logic slow_en;
      logic fast_int_en;
      logic fast_ext_en;
      logic fast_freq_500;
      logic slow_xtal_sel;
      logic slow_rc_sel;
   } csbc_osc_ctl_t;

   // clock routing: high = fast oscillator
   typedef struct packed {
      logic sys_fast;
      logic prediv_fast;
      logic periph_fast;
   } csbc_clk_sel_t;

   // power path and drive controls
   typedef struct packed {
      logic halver_switch_a;
      logic halver_switch_b;
      logic high_rail;
      logic high_drive;
   } csbc_power_t;

endpackage : csbc_pkg

// file: core/csbc_switch.sv
// system clock switch between slow and fast oscillators (dual builds)
// assumes oscillator edge pulses are one CLK cycle wide and synchronous
`timescale 1ns/10ps
`include "csbc_defines.svh"

module csbc_switch #(
   parameter int FAST_WAIT = `CSBC_FAST_WAIT,
   parameter int SLOW_WAIT = `CSBC_SLOW_WAIT,
   parameter int CNT_W = `CSBC_CNT_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // build and requests
   input wire logic enable,
   input wire logic fast_cmd,
   input wire logic slow_cmd,
   input wire logic halt_mode,
   input wire logic stop_mode,
   // oscillator edges
   input wire logic fast_edge,
   input wire logic slow_edge,
   // results
   output logic fast_osc_on,
   output logic sys_on_fast
);
   localparam int FW = FAST_WAIT - 1;
   localparam int SW = SLOW_WAIT - 1;
   localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FW);
   localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SW);

   csbc_pkg::csbc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;

   // sleep modes outrank both instructions
   wire sleep = halt_mode | stop_mode;
   wire go_fast = enable & fast_cmd & ~sleep;
   wire go_slow = slow_cmd & ~sleep;

   // state sequencing
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         csbc_pkg::CSBC_ST_SLOW: begin
            cnt_next = '0;
            if (go_fast) begin
               state_next = csbc_pkg::CSBC_ST_WAIT_FAST;
            end
         end
         csbc_pkg::CSBC_ST_WAIT_FAST: begin
            if (sleep | slow_cmd) begin
               state_next = csbc_pkg::CSBC_ST_SLOW;
            end else if (fast_edge && cnt_reg == FAST_LAST) begin
               state_next = csbc_pkg::CSBC_ST_FAST;
               cnt_next = '0;
            end else if (fast_edge) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         csbc_pkg::CSBC_ST_FAST: begin
            cnt_next = '0;
            // halt or stop leave at once
            if (sleep) begin
               state_next = csbc_pkg::CSBC_ST_SLOW;
            end else if (go_slow) begin
               state_next = csbc_pkg::CSBC_ST_WAIT_SLOW;
            end
         end
         csbc_pkg::CSBC_ST_WAIT_SLOW: begin
            if (sleep || (slow_edge && cnt_reg == SLOW_LAST)) begin
               state_next = csbc_pkg::CSBC_ST_SLOW;
               cnt_next = '0;
            end else if (slow_edge) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = csbc_pkg::CSBC_ST_SLOW;
            cnt_next = '0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= csbc_pkg::CSBC_ST_SLOW;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // fast stays on through the slow wait: the system still runs on it
   assign fast_osc_on = (state_reg != csbc_pkg::CSBC_ST_SLOW);
   assign sys_on_fast = (state_reg == csbc_pkg::CSBC_ST_FAST) |
                        (state_reg == csbc_pkg::CSBC_ST_WAIT_SLOW);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_fast_req;
      state_reg == csbc_pkg::CSBC_ST_SLOW && go_fast;
   endsequence
   sequence s_last_fast_edge;
      state_reg == csbc_pkg::CSBC_ST_WAIT_FAST && !sleep && !slow_cmd
         && fast_edge && cnt_reg == FAST_LAST;
   endsequence

   a_fast_start: assert property (s_fast_req |=> fast_osc_on && !sys_on_fast)
      else $error("fast oscillator not started by instruction");
   a_fast_count: assert property ($rose(sys_on_fast) |-> $past(fast_edge) && $past(cnt_reg) == FAST_LAST)
      else $error("system clock moved to fast before twelve edges");
   a_fast_arrive: assert property (s_last_fast_edge |=> sys_on_fast)
      else $error("system clock did not move to fast after wait");
   a_slow_count: assert property ($fell(sys_on_fast) && !$past(sleep) |-> $past(slow_edge) && $past(cnt_reg) == SLOW_LAST)
      else $error("system clock moved back before two slow edges");
   a_sleep_exit: assert property (sleep |=> !fast_osc_on && !sys_on_fast)
      else $error("halt or stop left fast oscillator running");

endmodule // csbc_switch

// file: sim/csbc_top_tb_top.sv
// testbench for the clock source and backup control block
// assumes csbc_pkg compiled first; oscillator inputs are slow pulses made here
`timescale 1ns/10ps

module csbc_top_tb_top;
   logic clk;
   logic rst;
   logic slow_osc;
   logic fast_osc;
   logic fast_insn;
   logic slow_insn;
   logic halt_mode;
   logic stop_mode;
   logic flag_wr;
   logic flag_wdata;
   logic flag_d;
   logic flag_e;
   logic mode_d;
   logic mode_e;
   csbc_pkg::csbc_osc_ctl_t osc_d;
   csbc_pkg::csbc_osc_ctl_t osc_e;
   csbc_pkg::csbc_clk_sel_t sel_d;
   csbc_pkg::csbc_clk_sel_t sel_e;
   csbc_pkg::csbc_power_t pwr_d;
   csbc_pkg::csbc_power_t pwr_e;
   logic flag_s;
   logic mode_s;
   csbc_pkg::csbc_osc_ctl_t osc_s;
   csbc_pkg::csbc_clk_sel_t sel_s;
   csbc_pkg::csbc_power_t pwr_s;
   int n_fail;
   int n_compared;

   // dual build on lithium with half bias: switching and halver paths
   csbc_top #(.CLOCK_SOURCE(csbc_pkg::CSBC_SRC_DUAL), .SUPPLY(csbc_pkg::CSBC_SUP_LI),
      .BIAS(csbc_pkg::CSBC_BIAS_HALF), .SLOW_TYPE(csbc_pkg::CSBC_SLOW_XTAL),
      .FAST_FREQ(csbc_pkg::CSBC_FREQ_500K)) u_dut (
      .CLK(clk), .RST(rst), .SLOW_OSC_CLK(slow_osc), .HIGH_SPEED_OSC_CLK(fast_osc),
      .FAST_INSN(fast_insn), .SLOW_INSN(slow_insn), .HALT_MODE(halt_mode), .STOP_MODE(stop_mode),
      .BACKUP_FLAG_WR(flag_wr), .BACKUP_FLAG_WDATA(flag_wdata), .BACKUP_DRIVE_FLAG(flag_d),
      .OSC_CTL(osc_d), .CLK_SEL(sel_d), .POWER_CTL(pwr_d), .FAST_MODE(mode_d));

   // fast-only external resistor build on external supply, same stimulus
   csbc_top #(.CLOCK_SOURCE(csbc_pkg::CSBC_SRC_FAST_EXT), .SUPPLY(csbc_pkg::CSBC_SUP_EXTERNAL_VOLTAGE_SUPPLY_OPTION),
      .BIAS(csbc_pkg::CSBC_BIAS_THIRD), .SLOW_TYPE(csbc_pkg::CSBC_SLOW_RC),
      .FAST_FREQ(csbc_pkg::CSBC_FREQ_250K)) u_ext (
      .CLK(clk), .RST(rst), .SLOW_OSC_CLK(slow_osc), .HIGH_SPEED_OSC_CLK(fast_osc),
      .FAST_INSN(fast_insn), .SLOW_INSN(slow_insn), .HALT_MODE(halt_mode), .STOP_MODE(stop_mode),
      .BACKUP_FLAG_WR(flag_wr), .BACKUP_FLAG_WDATA(flag_wdata), .BACKUP_DRIVE_FLAG(flag_e),
      .OSC_CTL(osc_e), .CLK_SEL(sel_e), .POWER_CTL(pwr_e), .FAST_MODE(mode_e));

   // slow-only rc build on silver-oxide: instructions must do nothing here
   csbc_top #(.CLOCK_SOURCE(csbc_pkg::CSBC_SRC_SLOW_ONLY), .SUPPLY(csbc_pkg::CSBC_SUP_AG),
      .BIAS(csbc_pkg::CSBC_BIAS_HALF), .SLOW_TYPE(csbc_pkg::CSBC_SLOW_RC),
      .FAST_FREQ(csbc_pkg::CSBC_FREQ_250K)) u_slo (
      .CLK(clk), .RST(rst), .SLOW_OSC_CLK(slow_osc), .HIGH_SPEED_OSC_CLK(fast_osc),
      .FAST_INSN(fast_insn), .SLOW_INSN(slow_insn), .HALT_MODE(halt_mode), .STOP_MODE(stop_mode),
      .BACKUP_FLAG_WR(flag_wr), .BACKUP_FLAG_WDATA(flag_wdata), .BACKUP_DRIVE_FLAG(flag_s),
      .OSC_CTL(osc_s), .CLK_SEL(sel_s), .POWER_CTL(pwr_s), .FAST_MODE(mode_s));

   // 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // n cycles, each landing just after the edge so inputs never race it
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // oscillator pulses: high one cycle, low one cycle, so each edge is seen
   task automatic pulse(input bit fast, input int n);
      repeat (n) begin
         if (fast) fast_osc = 1'h1; else slow_osc = 1'h1;
         step(1);
         if (fast) fast_osc = 1'h0; else slow_osc = 1'h0;
         step(1);
      end
   endtask

   task automatic wr(input logic v);
      flag_wr = 1'h1;
      flag_wdata = v;
      step(1);
      flag_wr = 1'h0;
      step(1);
   endtask

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic t_reset;
      step(1);
      chk(flag_d, 1'h1, "flag after reset, lithium");
      chk(flag_e, 1'h0, "flag after reset, external");
      chk(flag_s, 1'h1, "flag after reset, silver-oxide");
      step(1);
      chk(osc_d.slow_en, 1'h1, "slow osc on, dual");
      chk(osc_d.slow_xtal_sel, 1'h1, "crystal kind");
      chk(osc_e.slow_rc_sel, 1'h0, "no slow kind, fast only");
      chk(osc_s.slow_rc_sel, 1'h1, "rc kind, slow only");
      chk(osc_s.slow_xtal_sel, 1'h0, "no crystal, slow only");
      chk(osc_s.slow_en, 1'h1, "slow osc on, slow only");
      chk(sel_s, 3'h0, "slow-only routing");
      chk(pwr_s[3:1], 3'h0, "no halver, silver-oxide");
      chk(mode_e, 1'h1, "fast-only system clock");
      chk(osc_d.fast_int_en, 1'h0, "fast osc idle, dual");
      chk(osc_d.fast_freq_500, 1'h1, "internal rc 500k");
      chk(osc_e.slow_en, 1'h0, "slow osc off, fast only");
      chk(osc_e.fast_ext_en, 1'h1, "external rc on");
      chk(osc_e.fast_int_en, 1'h0, "internal rc off");
      chk(sel_d, 3'h0, "dual routing at start");
      chk(sel_e, 3'h7, "fast-only routing");
      chk(pwr_d, 4'h7, "lithium power, flag one");
      chk(pwr_e[3:1], 3'h0, "no halver, external supply");
      $display("test reset done");
   endtask

   task automatic t_flag;
      wr(1'h0);
      chk(flag_d, 1'h0, "flag readback zero");
      chk(pwr_d, 4'h8, "switch a closed, b open");
      wr(1'h1);
      chk(flag_d, 1'h1, "flag readback one");
      chk(pwr_d, 4'h7, "switch b closed, strong drive");
      chk(pwr_e[0], 1'h1, "drive follows flag, external");
      wr(1'h0);
      chk(pwr_d, 4'h8, "back to low drive");
      $display("test flag done");
   endtask

   // twelve fast edges after the request before the system clock moves
   task automatic go_fast;
      fast_insn = 1'h1;
      step(1);
      fast_insn = 1'h0;
      step(1);
      chk(osc_d.fast_int_en, 1'h1, "fast osc started");
      pulse(1'b1, 11);
      step(1);
      chk(mode_d, 1'h0, "still slow after 11 edges");
      pulse(1'b1, 1);
      step(1);
      chk(mode_d, 1'h1, "fast after 12 edges");
      chk(sel_d[1:0], 2'h0, "others stay slow");
      chk(mode_s, 1'h0, "instruction ignored, slow only");
      chk(osc_s.fast_int_en, 1'h0, "no fast osc, slow only");
      chk(mode_e, 1'h1, "fast-only clock unmoved");
   endtask

   task automatic t_switch;
      go_fast;
      slow_insn = 1'h1;
      step(1);
      slow_insn = 1'h0;
      pulse(1'b0, 1);
      step(1);
      chk(mode_d, 1'h1, "held after one slow edge");
      pulse(1'b0, 1);
      step(1);
      chk(mode_d, 1'h0, "slow after two edges");
      chk(osc_d.fast_int_en, 1'h0, "fast osc stopped");
      $display("test switch done");
   endtask

   task automatic t_halt;
      go_fast;
      halt_mode = 1'h1;
      step(3);
      chk(mode_d, 1'h0, "halt returns to slow");
      chk(osc_d.fast_int_en, 1'h0, "halt stops fast osc");
      fast_insn = 1'h1;
      step(1);
      fast_insn = 1'h0;
      step(3);
      chk(osc_d.fast_int_en, 1'h0, "request refused in halt");
      halt_mode = 1'h0;
      step(1);
      $display("test halt done");
   endtask

   task automatic t_stop;
      go_fast;
      stop_mode = 1'h1;
      step(3);
      chk(mode_d, 1'h0, "stop returns to slow");
      chk(osc_d.fast_int_en, 1'h0, "stop stops fast osc");
      chk(osc_d.slow_en, 1'h0, "stop halts slow osc");
      chk(osc_e.fast_ext_en, 1'h0, "stop halts external rc");
      chk(flag_s, 1'h1, "stop entry raises flag, single clock");
      chk(flag_d, 1'h0, "dual flag kept through stop");
      stop_mode = 1'h0;
      step(2);
      chk(osc_d.slow_en, 1'h1, "slow osc resumes");
      $display("test stop done");
   endtask

   // a low-speed request in the start-up wait must abandon the switch
   task automatic t_abort;
      fast_insn = 1'h1;
      step(1);
      fast_insn = 1'h0;
      slow_insn = 1'h1;
      step(1);
      slow_insn = 1'h0;
      pulse(1'b1, 12);
      step(1);
      chk(mode_d, 1'h0, "aborted switch stays slow");
      chk(osc_d.fast_int_en, 1'h0, "aborted fast osc off");
      $display("test abort done");
   endtask

   // watchdog: the whole sequence needs well under two thousand cycles
   initial begin
      #20000;
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run;
   end

   initial begin
      n_fail = 0;
      n_compared = 0;
      rst = 1'h1;
      slow_osc = 1'h0;
      fast_osc = 1'h0;
      fast_insn = 1'h0;
      slow_insn = 1'h0;
      halt_mode = 1'h0;
      stop_mode = 1'h0;
      flag_wr = 1'h0;
      flag_wdata = 1'h0;
      step(20);
      rst = 1'h0;
      t_reset;
      t_flag;
      t_switch;
      t_halt;
      t_stop;
      t_abort;
      complete_run;
   end
endmodule // csbc_top_tb_top
